// ==== common/wp_pkg.sv ====
`include "wp_regs.svh"

package wp_pkg;

  typedef struct packed {
    logic protect_enable;
    logic [31:0] schmitt;
    logic [`SOURCE_WIDTH-1:0] violation_source;
    logic [`IRQ_WIDTH-1:0] irq_mask;
    logic [31:0] rdata;
    logic cfg_wr;
    logic [11:0] cfg_offset;
    logic [31:0] cfg_wdata;
  } wp_state_t;

endpackage

// ==== common/wp_regs.svh ====
`ifndef WP_REGS_SVH
`define WP_REGS_SVH

// register byte addresses
`define LINE_LOCK_STATUS_ADDR 32'h400e_0ee0
`define WRITE_PROTECT_MODE_ADDR 32'h400e_0ee4
`define WRITE_PROTECT_STATUS_ADDR 32'h400e_0ee8
`define SCHMITT_TRIGGER_CONTROL_ADDR 32'h400e_0f00
`define IRQ_STATUS_ADDR 32'h400e_0ef0
`define IRQ_MASK_ADDR 32'h400e_0ef4

// guarded configuration register offsets (low 12 address bits)
`define LINE_ENABLE_OFS 12'h000
`define LINE_DISABLE_OFS 12'h004
`define OUT_ENABLE_OFS 12'h010
`define OUT_DISABLE_OFS 12'h014
`define FILTER_ENABLE_OFS 12'h020
`define FILTER_DISABLE_OFS 12'h024
`define MULTI_DRIVE_ENABLE_OFS 12'h050
`define MULTI_DRIVE_DISABLE_OFS 12'h054
`define PULL_UP_DISABLE_OFS 12'h060
`define PULL_UP_ENABLE_OFS 12'h064
`define PERIPH_SELECT_1_OFS 12'h070
`define PERIPH_SELECT_2_OFS 12'h074
`define PULL_DOWN_DISABLE_OFS 12'h090
`define PULL_DOWN_ENABLE_OFS 12'h094
`define OUT_WRITE_ENABLE_OFS 12'h0a0
`define OUT_WRITE_DISABLE_OFS 12'h0a4
`define CTRL_BASE 20'h400e_0

// fields
`define PROTECT_ENABLE_BIT 0
`define PROTECT_KEY_LSB 8
`define PROTECT_KEY_MSB 31
`define PROTECT_KEY_VALUE 24'h50_494f
`define VIOLATION_FLAG_BIT 0
`define VIOLATION_SOURCE_LSB 8
`define VIOLATION_SOURCE_MSB 23
`define SOURCE_WIDTH 16
`define IRQ_VIOLATION_BIT 0
`define IRQ_WIDTH 1

// reset values
`define PROTECT_ENABLE_RESET 1'b0
`define SCHMITT_RESET 32'h0000_0000
`define IRQ_MASK_RESET 1'b0

`endif

// ==== rtl/io_write_protect_lock_status.sv ====
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns

`include "wp_regs.svh"

module io_write_protect_lock_status
  import wp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] line_lock,
  output logic protect_enable,
  output logic [31:0] schmitt_disable_bit,
  output logic cfg_wr,
  output logic [11:0] cfg_offset,
  output logic [31:0] cfg_wdata,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  wp_state_t state;
  wp_state_t next_state;

  logic in_ctrl;
  logic [11:0] offset;
  logic guarded;
  logic key_ok;
  logic violation_set;
  logic status_read;
  logic irq_read;
  logic sel_status;
  logic sel_irq_status;
  logic [31:0] mode_word;
  logic [31:0] status_word;
  logic violation_flag;
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_set;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic is_guarded(input logic [11:0] ofs);
    logic hit;
    hit = 1'b0;
    // offsets only; the controller base is matched outside
    case (ofs)
      `LINE_ENABLE_OFS:
      begin
        hit = 1'b1;
      end
      `LINE_DISABLE_OFS:
      begin
        hit = 1'b1;
      end
      `OUT_ENABLE_OFS:
      begin
        hit = 1'b1;
      end
      `OUT_DISABLE_OFS:
      begin
        hit = 1'b1;
      end
      `FILTER_ENABLE_OFS:
      begin
        hit = 1'b1;
      end
      `FILTER_DISABLE_OFS:
      begin
        hit = 1'b1;
      end
      `MULTI_DRIVE_ENABLE_OFS:
      begin
        hit = 1'b1;
      end
      `MULTI_DRIVE_DISABLE_OFS:
      begin
        hit = 1'b1;
      end
      `PULL_UP_DISABLE_OFS:
      begin
        hit = 1'b1;
      end
      `PULL_UP_ENABLE_OFS:
      begin
        hit = 1'b1;
      end
      `PERIPH_SELECT_1_OFS:
      begin
        hit = 1'b1;
      end
      `PERIPH_SELECT_2_OFS:
      begin
        hit = 1'b1;
      end
      `PULL_DOWN_DISABLE_OFS:
      begin
        hit = 1'b1;
      end
      `PULL_DOWN_ENABLE_OFS:
      begin
        hit = 1'b1;
      end
      `OUT_WRITE_ENABLE_OFS:
      begin
        hit = 1'b1;
      end
      `OUT_WRITE_DISABLE_OFS:
      begin
        hit = 1'b1;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // source code is the attempted offset; upper nibble kept for codes
  function automatic logic [`SOURCE_WIDTH-1:0] source_code(
    input logic [11:0] ofs
  );
    logic [`SOURCE_WIDTH-1:0] code;
    code = {4'h0, ofs};
    return code;
  endfunction

  assign in_ctrl = (reg_addr[31:12] == `CTRL_BASE);
  assign offset = reg_addr[11:0];
  assign guarded = in_ctrl && is_guarded(offset);

  assign key_ok =
    (reg_wdata[`PROTECT_KEY_MSB:`PROTECT_KEY_LSB] == `PROTECT_KEY_VALUE);

  // a blocked write is the only event that raises a violation
  assign violation_set = reg_wr && guarded && state.protect_enable;

  assign sel_status = (reg_addr == `WRITE_PROTECT_STATUS_ADDR);
  assign sel_irq_status = (reg_addr == `IRQ_STATUS_ADDR);
  assign status_read = reg_rd && sel_status;
  assign irq_read = reg_rd && sel_irq_status;

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags

  sticky_flags #(
    .WIDTH(1)
  )
  u_violation
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .set(violation_set),
    .clear(status_read),
    .flags(violation_flag)
  );

  always_comb
  begin
    irq_set = '0;
    irq_set[`IRQ_VIOLATION_BIT] = violation_set;
  end

  sticky_flags #(
    .WIDTH(`IRQ_WIDTH)
  )
  u_irq_status
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .set(irq_set),
    .clear(irq_read),
    .flags(irq_status)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read-back words

  // key bits stay zero so the key can never be read back
  always_comb
  begin
    mode_word = 32'h0000_0000;
    mode_word[`PROTECT_ENABLE_BIT] = state.protect_enable;
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`VIOLATION_FLAG_BIT] = violation_flag;
    status_word[`VIOLATION_SOURCE_MSB:`VIOLATION_SOURCE_LSB] =
      state.violation_source;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_state = state;
    next_state.cfg_wr = 1'b0;
    next_state.rdata = 32'h0000_0000;

    // guarded writes pass on only while protection is off
    if (reg_wr && guarded && !state.protect_enable)
    begin
      next_state.cfg_wr = 1'b1;
      next_state.cfg_offset = offset;
      next_state.cfg_wdata = reg_wdata;
    end

    if (reg_wr)
    begin
      case (reg_addr)
        `WRITE_PROTECT_MODE_ADDR:
        begin
          // key mismatch drops the enable update entirely
          if (key_ok)
          begin
            next_state.protect_enable =
              reg_wdata[`PROTECT_ENABLE_BIT];
          end
        end
        `SCHMITT_TRIGGER_CONTROL_ADDR:
        begin
          next_state.schmitt = reg_wdata;
        end
        `IRQ_MASK_ADDR:
        begin
          next_state.irq_mask = reg_wdata[`IRQ_WIDTH-1:0];
        end
        `LINE_LOCK_STATUS_ADDR:
        begin
          // read-only: the write is dropped and raises no violation
        end
        `WRITE_PROTECT_STATUS_ADDR:
        begin
          // read-only: clearing happens only through a read
        end
        `IRQ_STATUS_ADDR:
        begin
          // read-only: clearing happens only through a read
        end
        default:
        begin
          next_state.irq_mask = next_state.irq_mask;
        end
      endcase
    end

    // source follows the flag: cleared on read, new event wins
    if (status_read)
    begin
      next_state.violation_source = '0;
    end
    if (violation_set)
    begin
      next_state.violation_source = source_code(offset);
    end

    if (reg_rd)
    begin
      case (reg_addr)
        `LINE_LOCK_STATUS_ADDR:
        begin
          next_state.rdata = line_lock;
        end
        `WRITE_PROTECT_MODE_ADDR:
        begin
          next_state.rdata = mode_word;
        end
        `WRITE_PROTECT_STATUS_ADDR:
        begin
          next_state.rdata = status_word;
        end
        `SCHMITT_TRIGGER_CONTROL_ADDR:
        begin
          next_state.rdata = state.schmitt;
        end
        `IRQ_STATUS_ADDR:
        begin
          next_state.rdata[`IRQ_WIDTH-1:0] = irq_status;
        end
        `IRQ_MASK_ADDR:
        begin
          next_state.rdata[`IRQ_WIDTH-1:0] = state.irq_mask;
        end
        default:
        begin
          next_state.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state.protect_enable <= `PROTECT_ENABLE_RESET;
      state.schmitt <= `SCHMITT_RESET;
      state.violation_source <= '0;
      state.irq_mask <= `IRQ_MASK_RESET;
      state.rdata <= 32'h0000_0000;
      state.cfg_wr <= 1'b0;
      state.cfg_offset <= 12'h000;
      state.cfg_wdata <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = state.rdata;
  assign protect_enable = state.protect_enable;
  assign schmitt_disable_bit = state.schmitt;
  assign cfg_wr = state.cfg_wr;
  assign cfg_offset = state.cfg_offset;
  assign cfg_wdata = state.cfg_wdata;
  // level output: stays high until the irq status read clears the bit or irq_mask is cleared
  assign irq = |(irq_status & state.irq_mask);

endmodule

// ==== rtl/sticky_flags.sv ====
`timescale 1ns/1ns

// flags set by hardware events, cleared by software; set beats clear
module sticky_flags #(
  parameter int WIDTH = 1
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] set,
  input wire logic clear,
  output logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } sticky_state_t;

  sticky_state_t state;
  sticky_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (clear)
    begin
      next_state.flags = '0;
    end
    next_state.flags = next_state.flags | set;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign flags = state.flags;

endmodule

// ==== verification/io_write_protect_lock_status_tb_top.sv ====
`timescale 1ns/1ns
`include "wp_regs.svh"
module io_write_protect_lock_status_tb_top;
  logic clk_sys, nrst, reg_wr, reg_rd, protect_enable, cfg_wr, irq, sc, si;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, line_lock;
  logic [31:0] schmitt_disable_bit, cfg_wdata, sd;
  logic [11:0] cfg_offset, so;
  logic [23:0] key = `PROTECT_KEY_VALUE;
  int errors, checked;
  logic [11:0] gofs [16] = '{12'h000, 12'h004, 12'h010, 12'h014, 12'h020,
    12'h024, 12'h050, 12'h054, 12'h060, 12'h064, 12'h070, 12'h074,
    12'h090, 12'h094, 12'h0a0, 12'h0a4};
  io_write_protect_lock_status io_write_protect_lock_status_i (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_lock(line_lock),
    .protect_enable(protect_enable),
    .schmitt_disable_bit(schmitt_disable_bit), .cfg_wr(cfg_wr),
    .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata), .irq(irq));
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // outputs captured 1 ns after the strobe edge, once registers settled
  task wr(input logic [31:0] a, input logic [31:0] w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1 sc = cfg_wr;
    so = cfg_offset;
    sd = cfg_wdata;
    si = irq;
    @(posedge clk_sys);
  endtask
  task rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
    si = irq;
    @(posedge clk_sys);
  endtask
  task end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk("pe", protect_enable, 32'h0);
    chk("sch", schmitt_disable_bit, `SCHMITT_RESET);
    rdc("mode", `WRITE_PROTECT_MODE_ADDR, 32'h0);
    rdc("stat", `WRITE_PROTECT_STATUS_ADDR, 32'h0);
    $display("t_reset done");
  endtask
  task t_lock;
    line_lock <= 32'ha5a5_0f0f;
    rdc("lock", `LINE_LOCK_STATUS_ADDR, 32'ha5a5_0f0f);
    wr(`LINE_LOCK_STATUS_ADDR, 32'h0);
    rdc("lock", `LINE_LOCK_STATUS_ADDR, 32'ha5a5_0f0f);
    rdc("unmapped", 32'h400e_0efc, 32'h0);
    $display("t_lock done");
  endtask
  task t_schmitt;
    wr(`SCHMITT_TRIGGER_CONTROL_ADDR, 32'hdead_beef);
    chk("sch", schmitt_disable_bit, 32'hdead_beef);
    rdc("sch", `SCHMITT_TRIGGER_CONTROL_ADDR, 32'hdead_beef);
    $display("t_schmitt done");
  endtask
  task t_protect;
    wr(`WRITE_PROTECT_MODE_ADDR, {key, 8'h01});
    chk("pe", protect_enable, 32'h1);
    rdc("mode", `WRITE_PROTECT_MODE_ADDR, 32'h1);
    wr(`WRITE_PROTECT_MODE_ADDR, {key ^ 24'h00_0001, 8'h00});
    chk("pe", protect_enable, 32'h1);
    wr(`WRITE_PROTECT_MODE_ADDR, {key, 8'h00});
    chk("pe", protect_enable, 32'h0);
    wr(`WRITE_PROTECT_MODE_ADDR, 32'h0000_0001);
    chk("pe", protect_enable, 32'h0);
    $display("t_protect done");
  endtask
  task t_guard;
    for (int i = 0; i < 16; i++)
    begin
      wr({`CTRL_BASE, gofs[i]}, {20'h0, gofs[i]});
      chk("cfg_wr", sc, 32'h1);
      chk("cfg_offset", so, gofs[i]);
      chk("cfg_wdata", sd, {20'h0, gofs[i]});
    end
    rdc("stat", `WRITE_PROTECT_STATUS_ADDR, 32'h0);
    wr(`WRITE_PROTECT_MODE_ADDR, {key, 8'h01});
    for (int i = 0; i < 16; i++)
    begin
      wr({`CTRL_BASE, gofs[i]}, 32'hffff_ffff);
      chk("cfg_wr", sc, 32'h0);
      chk("cfg_wdata", sd, 32'h0000_00a4);
      rdc("stat", `WRITE_PROTECT_STATUS_ADDR, {12'h0, gofs[i], 8'h01});
      rdc("stat", `WRITE_PROTECT_STATUS_ADDR, 32'h0);
    end
    wr({`CTRL_BASE, gofs[0]}, 32'h0);
    wr({`CTRL_BASE, gofs[15]}, 32'h0);
    wr(`SCHMITT_TRIGGER_CONTROL_ADDR, 32'h0);
    rdc("stat", `WRITE_PROTECT_STATUS_ADDR, {12'h0, gofs[15], 8'h01});
    $display("t_guard done");
  endtask
  task t_irq;
    // violations left by t_guard must be cleared before irq can be judged
    rdc("irq_stat", `IRQ_STATUS_ADDR, 32'h1);
    rdc("irq_stat", `IRQ_STATUS_ADDR, 32'h0);
    wr(`IRQ_MASK_ADDR, 32'h1);
    chk("irq", si, 32'h0);
    wr({`CTRL_BASE, gofs[2]}, 32'h0);
    chk("irq", si, 32'h1);
    rdc("irq_stat", `IRQ_STATUS_ADDR, 32'h1);
    chk("irq", si, 32'h0);
    rdc("stat", `WRITE_PROTECT_STATUS_ADDR, {12'h0, gofs[2], 8'h01});
    wr(`IRQ_MASK_ADDR, 32'h0);
    wr({`CTRL_BASE, gofs[2]}, 32'h0);
    chk("irq", si, 32'h0);
    rdc("irq_stat", `IRQ_STATUS_ADDR, 32'h1);
    wr(`WRITE_PROTECT_MODE_ADDR, {key, 8'h00});
    $display("t_irq done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    line_lock = 32'h0;
    errors = 0;
    checked = 0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_lock;
    t_schmitt;
    t_protect;
    t_guard;
    t_irq;
    end_sim;
  end
  // tests need about 190 cycles; this leaves a wide margin
  initial
  begin
    #200_000;
    errors++;
    end_sim;
  end
endmodule

// ==== verification/wp_monitor.sv ====
`timescale 1ns/1ns
`include "wp_regs.svh"
module wp_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] line_lock,
  input wire logic protect_enable,
  input wire logic [31:0] schmitt_disable_bit,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_offset,
  input wire logic [31:0] cfg_wdata,
  input wire logic irq
);
  logic grd;
  logic km;
  logic rs;
  // guarded offsets share a bit pattern, cheaper than listing all 16
  assign grd = reg_addr[31:12] == `CTRL_BASE && reg_addr[11:8] == 4'h0 &&
    !reg_addr[3] && reg_addr[1:0] == 2'h0 && reg_addr[7:4] inside
    {4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha};
  assign km = reg_wr && reg_addr == `WRITE_PROTECT_MODE_ADDR;
  assign rs = reg_rd && reg_addr == `WRITE_PROTECT_STATUS_ADDR;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  a_lock_read: assert property (
    reg_rd && reg_addr == `LINE_LOCK_STATUS_ADDR |=>
    reg_rdata == $past(line_lock)) else $error("lock read");
  a_key_update: assert property (
    km && reg_wdata[31:8] == `PROTECT_KEY_VALUE |=>
    protect_enable == $past(reg_wdata[0])) else $error("keyed write");
  a_bad_key: assert property (
    km && reg_wdata[31:8] != `PROTECT_KEY_VALUE |=> $stable(protect_enable))
    else $error("bad key");
  a_key_zero: assert property (
    reg_rd && reg_addr == `WRITE_PROTECT_MODE_ADDR |=>
    reg_rdata[31:8] == 24'h0) else $error("key readback");
  a_guard_block: assert property (
    reg_wr && protect_enable && grd |=> !cfg_wr) else $error("guard");
  a_open_write: assert property (
    reg_wr && !protect_enable && grd |=> cfg_wr &&
    cfg_offset == $past(reg_addr[11:0]) && cfg_wdata == $past(reg_wdata))
    else $error("open write");
  a_viol_capture: assert property (
    reg_wr && protect_enable && grd ##1 !(reg_wr || reg_rd) ##1 rs |=>
    reg_rdata == {12'h0, $past(reg_addr[11:0], 3), 7'h0, 1'b1})
    else $error("capture");
  a_status_clear: assert property (
    rs ##1 !reg_wr ##1 rs |=> reg_rdata == 32'h0) else $error("clear");
  a_schmitt_write: assert property (
    reg_wr && reg_addr == `SCHMITT_TRIGGER_CONTROL_ADDR |=>
    schmitt_disable_bit == $past(reg_wdata)) else $error("schmitt");
  c_block: cover property (reg_wr && protect_enable && grd);
  c_irq: cover property (irq);
  c_stat: cover property (rs);
endmodule

bind io_write_protect_lock_status wp_monitor wp_monitor_i (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .line_lock(line_lock),
  .protect_enable(protect_enable),
  .schmitt_disable_bit(schmitt_disable_bit), .cfg_wr(cfg_wr),
  .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata), .irq(irq));
